// *** cmce_checker.sv ***
// checker: port protocol assertions of the command executor
module cmce_checker #(
	parameter logic [7:0] EXEC_VERSION = 8'h10
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic cmd_valid_i,
	input wire logic [15:0] cmd_data_i,
	input wire logic cmd_ready_o,
	input wire logic rsp_valid_o,
	input wire logic [15:0] rsp_data_o,
	input wire logic rsp_ready_i,
	input wire logic mem_valid_o,
	input wire cmce_pkg::cmce_mem_req_t mem_req_o,
	input wire logic mem_ack_i,
	input wire logic mem_fault_i,
	input wire logic [23:0] mem_rdata_i,
	input wire logic exec_reset_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);
	// ==========================================================
	// first answer word after a command word is the header
	logic hdr_due_q;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hdr_due_q <= 1'b0;
		end else if (cmd_valid_i && cmd_ready_o) begin
			hdr_due_q <= 1'b1;
		end else if (rsp_valid_o) begin
			hdr_due_q <= 1'b0;
		end
	end
	// ==========================================================
	// sequences
	sequence s_ver_cmd;
		cmd_valid_i && cmd_ready_o && cmd_data_i == 16'hB001;
	endsequence
	sequence s_ver_hdr;
		rsp_valid_o && rsp_data_o == {4'h1, 4'hB, EXEC_VERSION};
	endsequence
	sequence s_fault;
		mem_valid_o && mem_ack_i && mem_fault_i;
	endsequence
	// ==========================================================
	// properties
	property p_ver_hdr;
		s_ver_cmd |-> ##[2:8] s_ver_hdr;
	endproperty
	property p_ver_len;
		s_ver_hdr ##0 rsp_ready_i |=> ##[0:3] (rsp_valid_o && rsp_data_o == 16'h0002);
	endproperty
	property p_rsp_hold;
		rsp_valid_o && !rsp_ready_i && !(mem_ack_i && mem_fault_i) |=>
			rsp_valid_o && $stable(rsp_data_o);
	endproperty
	property p_mem_hold;
		mem_valid_o && !mem_ack_i |=> mem_valid_o && $stable(mem_req_o);
	endproperty
	property p_mem_gap;
		mem_valid_o && mem_ack_i |=> !mem_valid_o;
	endproperty
	property p_fault;
		s_fault |=> exec_reset_o ##1 !exec_reset_o;
	endproperty
	property p_fault_cause;
		exec_reset_o |-> $past(mem_valid_o && mem_ack_i && mem_fault_i);
	endproperty
	property p_fault_quiet;
		s_fault |=> !rsp_valid_o [*4];
	endproperty
	property p_busy;
		rsp_valid_o |-> !cmd_ready_o;
	endproperty
	property p_hdr_op;
		rsp_valid_o && hdr_due_q |-> rsp_data_o[15:12] inside {4'h1, 4'h2, 4'h3};
	endproperty
	a_ver_hdr: assert property (p_ver_hdr) else $error("version header wrong");
	a_ver_len: assert property (p_ver_len) else $error("version length wrong");
	a_rsp_hold: assert property (p_rsp_hold) else $error("response word moved");
	a_mem_hold: assert property (p_mem_hold) else $error("memory request moved");
	a_mem_gap: assert property (p_mem_gap) else $error("memory request not released");
	a_fault: assert property (p_fault) else $error("no reset pulse on fault");
	a_fault_cause: assert property (p_fault_cause) else $error("reset without fault");
	a_fault_quiet: assert property (p_fault_quiet) else $error("answer after fault");
	a_busy: assert property (p_busy) else $error("command taken while answering");
	a_hdr_op: assert property (p_hdr_op) else $error("bad answer opcode");
endmodule

bind cmce_top cmce_checker #(.EXEC_VERSION(EXEC_VERSION)) u_chk (.*);

// *** cmce_mem_model.sv ***
// partner: behavioural memory behind the executor's memory port
module cmce_mem_model #(
	parameter logic [23:0] MEM_TOP = 24'h00F000
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic mem_valid_i,
	input wire cmce_pkg::cmce_mem_req_t mem_req_i,
	input wire logic slow_i,
	input wire logic corrupt_i,
	output logic mem_ack_o,
	output logic mem_fault_o,
	output logic [23:0] mem_rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [23:0] store [logic [24:0]];
	logic [24:0] key;
	int wait_q;
	assign key = {mem_req_i.id_space, mem_req_i.addr};
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem_ack_o <= 1'b0;
			mem_fault_o <= 1'b0;
			mem_rdata_o <= 24'h000000;
			wait_q <= 0;
		end else begin
			mem_ack_o <= 1'b0;
			mem_fault_o <= 1'b0;
			// idle read lines change every cycle
			mem_rdata_o <= ~mem_rdata_o;
			if (mem_valid_i && !mem_ack_o) begin
				if (slow_i && wait_q < 3) begin
					wait_q <= wait_q + 1;
				end else begin
					wait_q <= 0;
					mem_ack_o <= 1'b1;
					mem_fault_o <= mem_req_i.addr >= MEM_TOP;
					if (mem_req_i.we) begin
						store[key] = corrupt_i ? ~mem_req_i.wdata : mem_req_i.wdata;
					end else if (store.exists(key)) begin
						mem_rdata_o <= store[key];
					end else begin
						mem_rdata_o <= mem_req_i.addr ^ 24'hA55A3C;
					end
				end
			end
		end
	end
endmodule

// *** cmce_pkg.sv ***
// package: constants and types of the code memory command executor
package cmce_pkg;

	// ==========================================================
	// command opcodes and fixed command lengths in words
	localparam logic [3:0] OP_READ_ID = 4'h1;
	localparam logic [3:0] OP_READ_CODE = 4'h2;
	localparam logic [3:0] OP_WRITE_ID = 4'h4;
	localparam logic [3:0] OP_WRITE_ROW = 4'h5;
	localparam logic [3:0] OP_VERSION = 4'hB;
	localparam logic [7:0] LEN_READ_ID = 8'h03;
	localparam logic [7:0] LEN_READ_CODE = 8'h04;
	localparam logic [7:0] LEN_WRITE_ID = 8'h04;
	localparam logic [7:0] LEN_WRITE_ROW = 8'h63;
	localparam logic [7:0] LEN_VERSION = 8'h01;

	// ==========================================================
	// response fields
	localparam logic [3:0] RSP_PASS = 4'h1;
	localparam logic [3:0] RSP_FAIL = 4'h2;
	localparam logic [3:0] RSP_NACK = 4'h3;
	localparam logic [7:0] QE_NONE = 8'h00;
	localparam logic [7:0] QE_VERIFY = 8'h01;
	localparam logic [15:0] RSP_HDR_WORDS = 16'h0002;
	localparam logic [7:0] ID_PAD = 8'h00;

	// ==========================================================
	// sizes
	localparam int ROW_WORDS = 96;
	localparam logic [16:0] ROW_INSTR = 17'h00040;
	localparam logic [16:0] ID_MAX = 17'h00100;
	localparam logic [23:0] ADDR_STEP = 24'h000002;
	localparam logic [4:0] ROW_ARG_BASE = 5'h03;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ARGS,
		ST_WR,
		ST_VERIFY,
		ST_EMIT,
		ST_RD_ID,
		ST_RD_CODE
	} cmce_state_t;

	typedef struct packed {
		logic [3:0] op;
		logic [3:0] last_cmd;
		logic [7:0] query_error_code;
	} cmce_hdr_t;

	typedef struct packed {
		logic id_space;
		logic we;
		logic [23:0] addr;
		logic [23:0] wdata;
	} cmce_mem_req_t;

endpackage

// *** cmce_tb_top.sv ***
// testbench: command executor against a behavioural memory
module cmce_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [15:0] c[$]; logic [15:0] r[$];} cmce_row_t;
	logic mclk_i, rst_n_i, cmd_valid_i, cmd_ready_o, rsp_valid_o, rsp_ready_i;
	logic mem_valid_o, mem_ack_i, mem_fault_i, exec_reset_o, slow, corrupt;
	logic [15:0] cmd_data_i, rsp_data_o;
	logic [23:0] mem_rdata_i, a, b;
	cmce_pkg::cmce_mem_req_t mem_req_o;
	int err_total, num_checks, stall, n;
	cmce_row_t rows[$];
	cmce_row_t t;
	`define CHK(x, y) begin num_checks++; if ((x) !== (y)) begin err_total++; \
		$display("CHECK FAILED t=%0t got %h exp %h", $time, x, y); end end
	cmce_top dut (.*);
	cmce_mem_model mem (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .mem_valid_i(mem_valid_o),
		.mem_req_i(mem_req_o), .slow_i(slow), .corrupt_i(corrupt), .mem_ack_o(mem_ack_i),
		.mem_fault_o(mem_fault_i), .mem_rdata_o(mem_rdata_i));
	// counts executive reset pulses
	always @(posedge mclk_i) begin
		if (exec_reset_o === 1'b1) begin
			n++;
		end
	end
	function automatic logic [15:0] idw(input logic [23:0] x);
		return {8'h00, 8'(x ^ 24'hA55A3C)};
	endfunction
	function automatic logic [15:0] lw(input logic [23:0] x);
		return 16'(x ^ 24'hA55A3C);
	endfunction
	function automatic logic [7:0] hb(input logic [23:0] x);
		return 8'((x ^ 24'hA55A3C) >> 16);
	endfunction
	function automatic logic [23:0] ins(input int i);
		return {8'(i) ^ 8'h5A, 8'(i * 3), 8'(255 - i)};
	endfunction
	task automatic send(input logic [15:0] w);
		logic rdy;
		int k;
		k = 0;
		cmd_valid_i = 1'b1;
		cmd_data_i = w;
		do begin
			rdy = cmd_ready_o;
			@(negedge mclk_i);
			k++;
		end while (rdy !== 1'b1 && k < 300);
		`CHK(rdy, 1'b1)
	endtask
	task automatic get(input logic [15:0] e);
		int k;
		k = 0;
		repeat (stall) @(negedge mclk_i);
		while (rsp_valid_o !== 1'b1 && k < 2000) begin
			@(negedge mclk_i);
			k++;
		end
		`CHK(rsp_valid_o, 1'b1)
		`CHK(rsp_data_o, e)
		rsp_ready_i = 1'b1;
		@(negedge mclk_i);
		rsp_ready_i = 1'b0;
		@(negedge mclk_i);
	endtask
	task automatic xact(input cmce_row_t r);
		foreach (r.c[i]) send(r.c[i]);
		cmd_valid_i = 1'b0;
		foreach (r.r[i]) get(r.r[i]);
		`CHK(rsp_valid_o, 1'b0)
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	initial begin
		#500000;
		err_total++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		conclude();
	end
	initial begin
		{rst_n_i, cmd_valid_i, rsp_ready_i, slow, corrupt} = 5'h00;
		cmd_data_i = 16'h0000;
		stall = 0;
		n = 0;
		rows.push_back('{'{16'hB001}, '{16'h1B10, 16'h0002}});
		rows.push_back('{'{16'h7001}, '{16'h3700, 16'h0002}});
		rows.push_back('{'{16'h8003, 16'h1234, 16'h5678}, '{16'h3800, 16'h0002}});
		rows.push_back('{'{16'h1003, 16'h0300, 16'h0100}, '{16'h1100, 16'h0005,
			idw(24'h100), idw(24'h102), idw(24'h104)}});
		rows.push_back('{'{16'h2004, 16'h0002, 16'h0000, 16'h0200}, '{16'h1200, 16'h0005,
			lw(24'h200), {hb(24'h202), hb(24'h200)}, lw(24'h202)}});
		rows.push_back('{'{16'h2004, 16'h0003, 16'h0000, 16'h0210}, '{16'h1200, 16'h0007,
			lw(24'h210), {hb(24'h212), hb(24'h210)}, lw(24'h212), lw(24'h214),
			{8'h00, hb(24'h214)}}});
		rows.push_back('{'{16'h2004, 16'h0000, 16'h0000, 16'h0200}, '{16'h1200, 16'h0002}});
		rows.push_back('{'{16'h4004, 16'h0000, 16'h0300, 16'h00A5}, '{16'h1400, 16'h0002}});
		rows.push_back('{'{16'h1003, 16'h0100, 16'h0300}, '{16'h1100, 16'h0003, 16'h00A5}});
		repeat (4) @(posedge mclk_i);
		@(negedge mclk_i);
		`CHK({cmd_ready_o, rsp_valid_o, mem_valid_o, exec_reset_o}, 4'h8)
		rst_n_i = 1'b1;
		foreach (rows[i]) xact(rows[i]);
		// row write, slow memory and stalled consumer
		t.c = '{16'h5063, 16'h0000, 16'h0400};
		for (int k = 0; k < 64; k += 2) begin
			a = ins(k);
			b = ins(k + 1);
			t.c.push_back(a[15:0]);
			t.c.push_back({b[23:16], a[23:16]});
			t.c.push_back(b[15:0]);
		end
		t.r = '{16'h1500, 16'h0002};
		slow = 1'b1;
		stall = 2;
		xact(t);
		a = ins(0);
		b = ins(1);
		t.c = '{16'h2004, 16'h0003, 16'h0000, 16'h0400};
		t.r = '{16'h1200, 16'h0007, a[15:0], {b[23:16], a[23:16]}, b[15:0]};
		a = ins(2);
		t.r.push_back(a[15:0]);
		t.r.push_back({8'h00, a[23:16]});
		xact(t);
		a = ins(63);
		t.c = '{16'h2004, 16'h0001, 16'h0000, 16'h047E};
		t.r = '{16'h1200, 16'h0004, a[15:0], {8'h00, a[23:16]}};
		xact(t);
		corrupt = 1'b1;
		t.c = '{16'h4004, 16'h0000, 16'h0310, 16'h005A};
		t.r = '{16'h2401, 16'h0002};
		xact(t);
		corrupt = 1'b0;
		// read past the implemented memory
		send(16'h1003);
		send(16'h0100);
		send(16'hF000);
		cmd_valid_i = 1'b0;
		get(16'h1100);
		get(16'h0003);
		repeat (20) @(negedge mclk_i);
		`CHK(n, 1)
		`CHK(rsp_valid_o, 1'b0)
		xact(rows[0]);
		// reset in mid-command
		send(16'h1003);
		send(16'h0300);
		cmd_valid_i = 1'b0;
		rst_n_i = 1'b0;
		@(negedge mclk_i);
		`CHK(cmd_ready_o, 1'b1)
		rst_n_i = 1'b1;
		xact(rows[1]);
		conclude();
	end
endmodule

// *** cmce_top.sv ***
// module: command interpreter serving an external programmer

module cmce_top #(
	parameter logic [7:0] EXEC_VERSION = 8'h10
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic cmd_valid_i,
	input wire logic [15:0] cmd_data_i,
	output logic cmd_ready_o,
	output logic rsp_valid_o,
	output logic [15:0] rsp_data_o,
	input wire logic rsp_ready_i,
	output logic mem_valid_o,
	output cmce_pkg::cmce_mem_req_t mem_req_o,
	input wire logic mem_ack_i,
	input wire logic mem_fault_i,
	input wire logic [23:0] mem_rdata_i,
	output logic exec_reset_o
);

	// ==========================================================
	// state
	cmce_pkg::cmce_state_t state_q, after_q;
	logic [3:0] op_q;
	logic [7:0] cmd_len_q, wcnt_q;
	logic [15:0] a1_q, a2_q, a3_q;
	localparam int ROW_WORDS_I = cmce_pkg::ROW_WORDS;
	logic [15:0] row_q [ROW_WORDS_I];
	logic [23:0] base_q;
	logic [16:0] idx_q, total_q;
	logic [15:0] wq0_q, wq1_q;
	logic [1:0] wq_cnt_q;
	logic [7:0] held_msb_q;
	logic fail_q;
	logic rsp_valid_q;
	logic [15:0] rsp_data_q;
	logic mem_valid_q;
	cmce_pkg::cmce_mem_req_t mem_req_q;
	logic exec_reset_q;

	// ==========================================================
	// combinational helpers
	logic push_w, acked_w, fault_w, issue_w, last_w, mismatch_w;
	logic [6:0] rw_base;
	logic [23:0] row_instr;
	logic [15:0] half_n;
	cmce_pkg::cmce_mem_req_t req_w;

	assign acked_w = mem_valid_q && mem_ack_i && !mem_fault_i;
	assign fault_w = mem_valid_q && mem_ack_i && mem_fault_i;
	assign push_w = (state_q == cmce_pkg::ST_EMIT) && (wq_cnt_q != 2'd0)
		&& (!rsp_valid_q || rsp_ready_i);
	assign last_w = (idx_q + 17'd1) == total_q;
	assign half_n = a1_q >> 1;

	// packed pair p occupies row words 3p..3p+2
	assign rw_base = {2'b00, idx_q[5:1]} + {1'b0, idx_q[5:1], 1'b0};
	assign row_instr = idx_q[0] ? {row_q[rw_base + 7'd1][15:8], row_q[rw_base + 7'd2]}
		: {row_q[rw_base + 7'd1][7:0], row_q[rw_base]};

	assign mismatch_w = (op_q == cmce_pkg::OP_WRITE_ID) ? (mem_rdata_i[7:0] != a3_q[7:0])
		: (mem_rdata_i != row_instr);

	assign issue_w = !mem_valid_q && (state_q == cmce_pkg::ST_WR
		|| state_q == cmce_pkg::ST_VERIFY
		|| ((state_q == cmce_pkg::ST_RD_ID || state_q == cmce_pkg::ST_RD_CODE)
		&& idx_q != total_q));

	always_comb begin
		req_w.id_space = (state_q == cmce_pkg::ST_RD_ID) || (op_q == cmce_pkg::OP_WRITE_ID);
		req_w.we = (state_q == cmce_pkg::ST_WR);
		req_w.addr = base_q + idx_q[15:0] * cmce_pkg::ADDR_STEP;
		if (op_q == cmce_pkg::OP_WRITE_ID) begin
			req_w.wdata = {16'h0000, a3_q[7:0]};
		end else begin
			req_w.wdata = row_instr;
		end
	end

	// next command waits until the last answer word is taken
	assign cmd_ready_o = (state_q == cmce_pkg::ST_IDLE && !rsp_valid_q)
		|| (state_q == cmce_pkg::ST_ARGS && wcnt_q != cmd_len_q);
	assign rsp_valid_o = rsp_valid_q;
	assign rsp_data_o = rsp_data_q;
	assign mem_valid_o = mem_valid_q;
	assign mem_req_o = mem_req_q;
	assign exec_reset_o = exec_reset_q;

	// ==========================================================
	// row data buffer
	always_ff @(posedge mclk_i) begin
		if (state_q == cmce_pkg::ST_ARGS && cmd_valid_i && cmd_ready_o
			&& wcnt_q >= {3'b000, cmce_pkg::ROW_ARG_BASE}
			&& op_q == cmce_pkg::OP_WRITE_ROW) begin
			row_q[7'(wcnt_q - {3'b000, cmce_pkg::ROW_ARG_BASE})] <= cmd_data_i;
		end
	end

	// ==========================================================
	// command sequencer
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= cmce_pkg::ST_IDLE;
			after_q <= cmce_pkg::ST_IDLE;
			op_q <= 4'h0;
			cmd_len_q <= 8'h00;
			wcnt_q <= 8'h00;
			a1_q <= 16'h0000;
			a2_q <= 16'h0000;
			a3_q <= 16'h0000;
			base_q <= 24'h000000;
			idx_q <= 17'h00000;
			total_q <= 17'h00000;
			wq0_q <= 16'h0000;
			wq1_q <= 16'h0000;
			wq_cnt_q <= 2'd0;
			held_msb_q <= 8'h00;
			fail_q <= 1'b0;
		end else if (fault_w) begin
			state_q <= cmce_pkg::ST_IDLE;
			wq_cnt_q <= 2'd0;
		end else begin
			unique case (state_q)
				cmce_pkg::ST_IDLE: begin
					if (cmd_valid_i && cmd_ready_o) begin
						op_q <= cmd_data_i[15:12];
						wcnt_q <= 8'd1;
						fail_q <= 1'b0;
						state_q <= cmce_pkg::ST_ARGS;
						unique case (cmd_data_i[15:12])
							cmce_pkg::OP_READ_ID: cmd_len_q <= cmce_pkg::LEN_READ_ID;
							cmce_pkg::OP_READ_CODE: cmd_len_q <= cmce_pkg::LEN_READ_CODE;
							cmce_pkg::OP_WRITE_ID: cmd_len_q <= cmce_pkg::LEN_WRITE_ID;
							cmce_pkg::OP_WRITE_ROW: cmd_len_q <= cmce_pkg::LEN_WRITE_ROW;
							cmce_pkg::OP_VERSION: cmd_len_q <= cmce_pkg::LEN_VERSION;
							default: begin
								cmd_len_q <= (cmd_data_i[7:0] == 8'h00) ? 8'h01 : cmd_data_i[7:0];
							end
						endcase
					end
				end
				cmce_pkg::ST_ARGS: begin
					if (wcnt_q != cmd_len_q) begin
						if (cmd_valid_i) begin
							wcnt_q <= wcnt_q + 8'd1;
							if (wcnt_q == 8'd1) a1_q <= cmd_data_i;
							if (wcnt_q == 8'd2) a2_q <= cmd_data_i;
							if (wcnt_q == 8'd3) a3_q <= cmd_data_i;
						end
					end else begin
						idx_q <= 17'h00000;
						wq_cnt_q <= 2'd2;
						wq1_q <= cmce_pkg::RSP_HDR_WORDS;
						after_q <= cmce_pkg::ST_IDLE;
						state_q <= cmce_pkg::ST_EMIT;
						unique case (op_q)
							cmce_pkg::OP_READ_ID: begin
								base_q <= {a1_q[7:0], a2_q};
								total_q <= (a1_q[15:8] == 8'h00) ? cmce_pkg::ID_MAX
									: {9'h000, a1_q[15:8]};
								wq0_q <= {cmce_pkg::RSP_PASS, op_q, cmce_pkg::QE_NONE};
								wq1_q <= cmce_pkg::RSP_HDR_WORDS + ((a1_q[15:8] == 8'h00)
									? cmce_pkg::ID_MAX[15:0] : {8'h00, a1_q[15:8]});
								after_q <= cmce_pkg::ST_RD_ID;
							end
							cmce_pkg::OP_READ_CODE: begin
								base_q <= {a2_q[7:0], a3_q};
								total_q <= {1'b0, a1_q};
								wq0_q <= {cmce_pkg::RSP_PASS, op_q, cmce_pkg::QE_NONE};
								wq1_q <= (a1_q[0] ? 16'd4 : cmce_pkg::RSP_HDR_WORDS)
									+ half_n + {half_n[14:0], 1'b0};
								after_q <= cmce_pkg::ST_RD_CODE;
							end
							cmce_pkg::OP_WRITE_ID: begin
								base_q <= {a1_q[7:0], a2_q};
								total_q <= 17'h00001;
								state_q <= cmce_pkg::ST_WR;
							end
							cmce_pkg::OP_WRITE_ROW: begin
								base_q <= {a1_q[7:0], a2_q};
								total_q <= cmce_pkg::ROW_INSTR;
								state_q <= cmce_pkg::ST_WR;
							end
							cmce_pkg::OP_VERSION: begin
								wq0_q <= {cmce_pkg::RSP_PASS, op_q, EXEC_VERSION};
							end
							default: begin
								wq0_q <= {cmce_pkg::RSP_NACK, op_q, cmce_pkg::QE_NONE};
							end
						endcase
					end
				end
				cmce_pkg::ST_WR: begin
					if (acked_w) begin
						if (last_w) begin
							idx_q <= 17'h00000;
							state_q <= cmce_pkg::ST_VERIFY;
						end else begin
							idx_q <= idx_q + 17'd1;
						end
					end
				end
				cmce_pkg::ST_VERIFY: begin
					if (acked_w) begin
						idx_q <= idx_q + 17'd1;
						if (mismatch_w) fail_q <= 1'b1;
						if (last_w) begin
							wq0_q <= (fail_q || mismatch_w)
								? {cmce_pkg::RSP_FAIL, op_q, cmce_pkg::QE_VERIFY}
								: {cmce_pkg::RSP_PASS, op_q, cmce_pkg::QE_NONE};
							wq1_q <= cmce_pkg::RSP_HDR_WORDS;
							wq_cnt_q <= 2'd2;
							after_q <= cmce_pkg::ST_IDLE;
							state_q <= cmce_pkg::ST_EMIT;
						end
					end
				end
				cmce_pkg::ST_EMIT: begin
					if (wq_cnt_q == 2'd0) begin
						state_q <= after_q;
					end else if (push_w) begin
						wq0_q <= wq1_q;
						wq_cnt_q <= wq_cnt_q - 2'd1;
					end
				end
				cmce_pkg::ST_RD_ID: begin
					if (idx_q == total_q && !mem_valid_q) begin
						state_q <= cmce_pkg::ST_IDLE;
					end else if (acked_w) begin
						wq0_q <= {cmce_pkg::ID_PAD, mem_rdata_i[7:0]};
						wq_cnt_q <= 2'd1;
						idx_q <= idx_q + 17'd1;
						state_q <= cmce_pkg::ST_EMIT;
					end
				end
				cmce_pkg::ST_RD_CODE: begin
					if (idx_q == total_q && !mem_valid_q) begin
						state_q <= cmce_pkg::ST_IDLE;
					end else if (acked_w) begin
						idx_q <= idx_q + 17'd1;
						state_q <= cmce_pkg::ST_EMIT;
						if (!idx_q[0]) begin
							held_msb_q <= mem_rdata_i[23:16];
							wq0_q <= mem_rdata_i[15:0];
							wq1_q <= {8'h00, mem_rdata_i[23:16]};
							wq_cnt_q <= last_w ? 2'd2 : 2'd1;
						end else begin
							wq0_q <= {mem_rdata_i[23:16], held_msb_q};
							wq1_q <= mem_rdata_i[15:0];
							wq_cnt_q <= 2'd2;
						end
					end
				end
			endcase
		end
	end

	// ==========================================================
	// response word output
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rsp_valid_q <= 1'b0;
			rsp_data_q <= 16'h0000;
		end else if (fault_w) begin
			rsp_valid_q <= 1'b0;
		end else if (push_w) begin
			rsp_valid_q <= 1'b1;
			rsp_data_q <= wq0_q;
		end else if (rsp_ready_i) begin
			rsp_valid_q <= 1'b0;
		end
	end

	// ==========================================================
	// memory port
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem_valid_q <= 1'b0;
			mem_req_q <= '0;
			exec_reset_q <= 1'b0;
		end else begin
			exec_reset_q <= fault_w;
			if (issue_w) begin
				mem_valid_q <= 1'b1;
				mem_req_q <= req_w;
			end else if (mem_ack_i) begin
				mem_valid_q <= 1'b0;
			end
		end
	end

endmodule
